/* hdl/sdcb_pkg.sv */
// Constants, types and helpers for the DRAM command and bank logic
package sdcb_pkg;

  // ----------------------------------------
  // Geometry and field positions
  // ----------------------------------------
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 16;
  localparam int A10_POS = 10;
  localparam int A12_POS = 12;
  localparam int BURST8 = 8;
  localparam int BURST4 = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_RP_PS = 13750;
  localparam int T_RFC_PS = 160000;
  localparam int T_RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ZQINIT_CYC = 512;
  localparam int ZQOPER_CYC = 256;
  localparam int ZQCS_CYC = 64;
  localparam int TMR_W = 10;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdcb_cmd_t;

  typedef enum logic [2:0] {
    SDCB_NOP = 3'h0,
    SDCB_ACT = 3'h1,
    SDCB_RD = 3'h2,
    SDCB_WR = 3'h3,
    SDCB_PRE = 3'h4,
    SDCB_REF = 3'h5,
    SDCB_ZQ = 3'h6
  } sdcb_op_t;

  typedef enum logic [1:0] {
    BANK_IDLE = 2'h0,
    BANK_OPEN = 2'h1,
    BANK_PRECH = 2'h3
  } sdcb_bank_t;

  typedef enum logic [1:0] {
    ZQ_IDLE = 2'h0,
    ZQ_RUN = 2'h1,
    ZQ_LOAD = 2'h3
  } sdcb_zq_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Command from pins; CKE low on either edge is outside this block
  function automatic sdcb_op_t sdcb_decode(input sdcb_cmd_t c, input logic cke_prev);
    sdcb_op_t op;
    op = SDCB_NOP;
    if (cke_prev && c.cke && !c.cs_n) begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'b011: op = SDCB_ACT;
        3'b101: op = SDCB_RD;
        3'b100: op = SDCB_WR;
        3'b010: op = SDCB_PRE;
        3'b001: op = SDCB_REF;
        3'b110: op = SDCB_ZQ;
        default: op = SDCB_NOP;
      endcase
    end
    return op;
  endfunction

  // Column of a beat: sequential or interleaved, chop wraps within four
  function automatic logic [2:0] sdcb_beat_col(input logic [2:0] start, input logic [2:0] beat,
                                               input logic chop, input logic ilv);
    logic [2:0] c;
    c = ilv ? (start ^ beat) : 3'(start + beat);
    if (chop) begin
      c[2] = ilv ? (start[2] ^ beat[2]) : start[2];
    end
    return c;
  endfunction

endpackage

/* hdl/sdcb_array.sv */
// Byte-masked storage array with registered read data
`timescale 1ns/1ps
module sdcb_array #(
  parameter int DW = 16,
  parameter int AW = 9
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [DW/8-1:0] wr_byte_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read side
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_q
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int b = 0; b < DW / 8; b++) begin
        if (wr_byte_en[b]) begin
          mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

/* hdl/sdcb_core.sv */
// Command decode, bank tracking, bursts, refresh and ZQ calibration
`timescale 1ns/1ps
module sdcb_core import sdcb_pkg::*; #(
  parameter int DQ_W = 16,
  parameter int ROW_LO_W = 2,
  parameter int COL_W = 4,
  parameter int REF_ROW_W = 13,
  parameter int ZQ_W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command pins
  input wire sdcb_cmd_t cmd,
  // Mode settings held by the mode register
  input wire logic otf_en,
  input wire logic fixed_chop,
  input wire logic burst_ilv,
  input wire logic init_done,
  // Write data
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic [DQ_W/8-1:0] dm_in,
  // Read data and write beat strobe
  output logic [DQ_W-1:0] dq_out_q,
  output logic dq_out_valid_q,
  output logic wr_beat,
  // Calibration
  input wire logic [ZQ_W-1:0] zq_meas_ron,
  input wire logic [ZQ_W-1:0] zq_meas_odt,
  output logic [ZQ_W-1:0] ron_code_q,
  output logic [ZQ_W-1:0] odt_code_q,
  output logic zq_busy,
  // Status
  output logic [BANKS-1:0] bank_open,
  output logic [BANKS-1:0] bank_prech,
  output logic [REF_ROW_W-1:0] ref_row_q,
  output logic ref_busy
);

  localparam int AW = BA_W + ROW_LO_W + COL_W;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic cke_prev_q;
  sdcb_op_t op;
  logic a10;
  logic chop_sel;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= cmd.cke;
    end
  end

  assign op = sdcb_decode(cmd, cke_prev_q);
  assign a10 = cmd.addr[A10_POS];
  assign chop_sel = otf_en ? !cmd.addr[A12_POS] : fixed_chop;

  // ----------------------------------------
  // Bank tracking
  // ----------------------------------------
  sdcb_bank_t bank_st_q [BANKS];
  logic [TMR_W-1:0] bank_tmr_q [BANKS];
  logic [ADDR_W-1:0] bank_row_q [BANKS];
  logic bst_act_q;
  logic bst_end;
  logic bst_ap_q;
  logic [BA_W-1:0] bst_ba_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int b = 0; b < BANKS; b++) begin
        bank_st_q[b] <= BANK_IDLE;
        bank_tmr_q[b] <= '0;
        bank_row_q[b] <= '0;
      end
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        case (bank_st_q[b])
          BANK_IDLE: begin
            if (op == SDCB_ACT && cmd.ba == BA_W'(b)) begin
              bank_st_q[b] <= BANK_OPEN;
              bank_row_q[b] <= cmd.addr;
            end
          end
          BANK_OPEN: begin
            if (op == SDCB_PRE && (a10 || cmd.ba == BA_W'(b))) begin
              bank_st_q[b] <= BANK_PRECH;
              bank_tmr_q[b] <= TMR_W'(T_RP_CYC - 1);
            end else if (bst_end && bst_ap_q && bst_ba_q == BA_W'(b)) begin
              bank_st_q[b] <= BANK_PRECH;
              bank_tmr_q[b] <= TMR_W'(T_RP_CYC - 1);
            end
          end
          BANK_PRECH: begin
            if (op == SDCB_PRE && (a10 || cmd.ba == BA_W'(b))) begin
              bank_tmr_q[b] <= TMR_W'(T_RP_CYC - 1);
            end else if (bank_tmr_q[b] == '0) begin
              bank_st_q[b] <= BANK_IDLE;
            end else begin
              bank_tmr_q[b] <= bank_tmr_q[b] - 1'b1;
            end
          end
          default: bank_st_q[b] <= BANK_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      bank_open[b] = (bank_st_q[b] == BANK_OPEN);
      bank_prech[b] = (bank_st_q[b] == BANK_PRECH);
    end
  end

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  // Read and write commands arriving mid-burst are dropped rather than cutting the burst
  logic bst_wr_q;
  logic bst_chop_q;
  logic [2:0] bst_beat_q;
  logic [2:0] bst_start_q;
  logic [COL_W-1:0] bst_col_q;
  logic [ROW_LO_W-1:0] bst_row_q;
  logic start_acc;
  logic [2:0] beat_col;
  logic [AW-1:0] beat_addr;
  logic rd_beat;

  assign start_acc = (op == SDCB_RD || op == SDCB_WR) && !bst_act_q
                     && bank_st_q[cmd.ba] == BANK_OPEN;
  assign bst_end = bst_act_q && bst_beat_q == (bst_chop_q ? 3'(BURST4 - 1) : 3'(BURST8 - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bst_act_q <= 1'b0;
      bst_wr_q <= 1'b0;
      bst_ap_q <= 1'b0;
      bst_chop_q <= 1'b0;
      bst_beat_q <= '0;
      bst_start_q <= '0;
      bst_col_q <= '0;
      bst_row_q <= '0;
      bst_ba_q <= '0;
    end else if (start_acc) begin
      bst_act_q <= 1'b1;
      bst_wr_q <= (op == SDCB_WR);
      bst_ap_q <= a10;
      bst_chop_q <= chop_sel;
      bst_beat_q <= '0;
      bst_start_q <= cmd.addr[2:0];
      bst_col_q <= cmd.addr[COL_W-1:0];
      bst_row_q <= bank_row_q[cmd.ba][ROW_LO_W-1:0];
      bst_ba_q <= cmd.ba;
    end else if (bst_act_q) begin
      bst_beat_q <= bst_beat_q + 3'h1;
      if (bst_end) begin
        bst_act_q <= 1'b0;
      end
    end
  end

  assign beat_col = sdcb_beat_col(bst_start_q, bst_beat_q, bst_chop_q, burst_ilv);
  assign beat_addr = {bst_ba_q, bst_row_q, bst_col_q[COL_W-1:3], beat_col};
  assign wr_beat = bst_act_q && bst_wr_q;
  assign rd_beat = bst_act_q && !bst_wr_q;

  sdcb_array #(
    .DW(DQ_W),
    .AW(AW)
  ) u_array (
    .clk(clk),
    .wr_en(wr_beat),
    .wr_byte_en(~dm_in),
    .wr_addr(beat_addr),
    .wr_data(dq_in),
    .rd_en(rd_beat),
    .rd_addr(beat_addr),
    .rd_data_q(dq_out_q)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_out_valid_q <= 1'b0;
    end else begin
      dq_out_valid_q <= rd_beat;
    end
  end

  // ----------------------------------------
  // Refresh
  // ----------------------------------------
  // Busy flag is status only; spacing is the controller's duty
  logic [TMR_W-1:0] ref_tmr_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_row_q <= '0;
      ref_tmr_q <= '0;
    end else if (op == SDCB_REF) begin
      ref_row_q <= ref_row_q + 1'b1;
      ref_tmr_q <= TMR_W'(T_RFC_CYC);
    end else if (ref_tmr_q != '0) begin
      ref_tmr_q <= ref_tmr_q - 1'b1;
    end
  end

  assign ref_busy = (ref_tmr_q != '0);

  // ----------------------------------------
  // ZQ calibration engine
  // ----------------------------------------
  sdcb_zq_t zq_st_q;
  logic [TMR_W-1:0] zq_tmr_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      zq_st_q <= ZQ_IDLE;
      zq_tmr_q <= '0;
      ron_code_q <= '0;
      odt_code_q <= '0;
    end else begin
      case (zq_st_q)
        ZQ_IDLE: begin
          if (op == SDCB_ZQ) begin
            zq_st_q <= ZQ_RUN;
            if (!cmd.addr[A10_POS]) begin
              zq_tmr_q <= TMR_W'(ZQCS_CYC - 2);
            end else if (!init_done) begin
              zq_tmr_q <= TMR_W'(ZQINIT_CYC - 2);
            end else begin
              zq_tmr_q <= TMR_W'(ZQOPER_CYC - 2);
            end
          end
        end
        ZQ_RUN: begin
          if (zq_tmr_q == '0) begin
            zq_st_q <= ZQ_LOAD;
          end else begin
            zq_tmr_q <= zq_tmr_q - 1'b1;
          end
        end
        ZQ_LOAD: begin
          ron_code_q <= zq_meas_ron;
          odt_code_q <= zq_meas_odt;
          zq_st_q <= ZQ_IDLE;
        end
        default: zq_st_q <= ZQ_IDLE;
      endcase
    end
  end

  assign zq_busy = (zq_st_q != ZQ_IDLE);

endmodule

/* verification/sdcb_ctl_model.sv */
// Controller model that places commands on the pins
`timescale 1ns/1ps
module sdcb_ctl_model import sdcb_pkg::*; (
  // Clock
  input wire logic clk,
  // Command pins
  output sdcb_cmd_t cmd
);
  initial cmd = {5'h17, 3'h0, 16'h0000};
  // One command then a NOP; idle fields flip so stale values never pass
  task automatic issue(input logic [2:0] op, input logic [2:0] ba, input logic [15:0] a);
    @(posedge clk);
    cmd <= {2'h2, op, ba, a};
    @(posedge clk);
    cmd <= {5'h17, ~ba, ~a};
  endtask
endmodule

/* verification/sdcb_core_chk.sv */
// Port assertions for the DRAM command and bank logic
`timescale 1ns/1ps
module sdcb_core_chk import sdcb_pkg::*; #(
  parameter int REF_ROW_W = 13,
  parameter int ZQ_W = 6
) (
  // Inputs
  input wire logic clk,
  input wire logic sys_rst,
  input wire sdcb_cmd_t cmd,
  input wire logic otf_en,
  input wire logic [ZQ_W-1:0] zq_meas_ron,
  // Outputs
  input wire logic dq_out_valid_q,
  input wire logic wr_beat,
  input wire logic [ZQ_W-1:0] ron_code_q,
  input wire logic zq_busy,
  input wire logic [BANKS-1:0] bank_open,
  input wire logic [BANKS-1:0] bank_prech,
  input wire logic [REF_ROW_W-1:0] ref_row_q,
  input wire logic ref_busy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic ck_q;
  logic [2:0] pb_q;
  logic [2:0] op;
  logic go, idl, a10;
  assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign go = ck_q && cmd.cke && !cmd.cs_n;
  // Bursts judged only from a quiet bus; back-to-back runs are left out
  assign idl = !dq_out_valid_q && !wr_beat && otf_en;
  assign a10 = cmd.addr[A10_POS];
  always_ff @(posedge clk) begin
    ck_q <= !sys_rst && cmd.cke;
  end
  always_ff @(posedge clk) begin
    if (go && op == 3'h2) begin
      pb_q <= cmd.ba;
    end
  end
  a_act_opens_row: assert property (
    go && op == 3'h3 && !bank_open[cmd.ba] && !bank_prech[cmd.ba]
    |=> bank_open[$past(cmd.ba)]) else $error("bank not opened");
  a_pre_all_close: assert property (
    go && op == 3'h2 && a10 |=> bank_open == 8'h00) else $error("bank left open");
  a_pre_trp_hold: assert property (
    go && op == 3'h2 && !a10 && (bank_open[cmd.ba] || bank_prech[cmd.ba])
    |=> bank_prech[pb_q] [*3]) else $error("precharge too short");
  a_pre_idle_nop: assert property (
    go && op == 3'h2 && !a10 && !bank_open[cmd.ba] && !bank_prech[cmd.ba]
    |=> !bank_prech[$past(cmd.ba)]) else $error("idle precharge acted");
  a_ref_row_step: assert property (
    go && op == 3'h1 && !ref_busy
    |=> ref_busy && ref_row_q == $past(ref_row_q) + 1'h1) else $error("refresh row stuck");
  a_zq_short_len: assert property (
    go && op == 3'h6 && !a10 && !zq_busy
    |-> ##64 zq_busy ##1 !zq_busy) else $error("short calibration length");
  a_zq_code_load: assert property (
    $fell(zq_busy) |-> ron_code_q == $past(zq_meas_ron)) else $error("codes not loaded");
  a_rd_chop_len: assert property (
    go && op == 3'h5 && bank_open[cmd.ba] && idl && !cmd.addr[A12_POS]
    |-> ##2 dq_out_valid_q [*4] ##1 !dq_out_valid_q) else $error("chop length");
  a_rd_autopre: assert property (
    go && op == 3'h5 && bank_open[cmd.ba] && idl && cmd.addr[A12_POS] && a10
    |-> ##2 dq_out_valid_q [*7] ##1 (dq_out_valid_q && bank_prech[$past(cmd.ba, 9)]))
    else $error("auto precharge timing");
endmodule

bind sdcb_core sdcb_core_chk #(.REF_ROW_W(REF_ROW_W), .ZQ_W(ZQ_W)) u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .cmd(cmd),
  .otf_en(otf_en),
  .zq_meas_ron(zq_meas_ron),
  .dq_out_valid_q(dq_out_valid_q),
  .wr_beat(wr_beat),
  .ron_code_q(ron_code_q),
  .zq_busy(zq_busy),
  .bank_open(bank_open),
  .bank_prech(bank_prech),
  .ref_row_q(ref_row_q),
  .ref_busy(ref_busy)
);

/* verification/sdcb_command_bank_logic_tb.sv */
// Self-checking bench for the DRAM command and bank logic
`timescale 1ns/1ps
module sdcb_command_bank_logic_tb import sdcb_pkg::*;;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic otf_en = 1'h1;
  logic fixed_chop = 1'h0;
  logic burst_ilv = 1'h0;
  logic init_done = 1'h1;
  logic [15:0] dq_in = 16'h0000;
  logic [1:0] dm_in = 2'h0;
  logic [5:0] zq_meas_ron = 6'h00;
  logic [5:0] zq_meas_odt = 6'h00;
  sdcb_cmd_t cmd;
  logic [15:0] dq_out_q;
  logic dq_out_valid_q, wr_beat, zq_busy, ref_busy;
  logic [5:0] ron_code_q, odt_code_q;
  logic [7:0] bank_open, bank_prech;
  logic [12:0] ref_row_q;
  logic [15:0] mem [8];
  int fail_count = 0;
  int n_compared = 0;
  int n;

  always #2.5 clk = ~clk;
  sdcb_ctl_model ctl (.clk(clk), .cmd(cmd));
  sdcb_core DUT (
    .clk(clk),
    .sys_rst(sys_rst),
    .cmd(cmd),
    .otf_en(otf_en),
    .fixed_chop(fixed_chop),
    .burst_ilv(burst_ilv),
    .init_done(init_done),
    .dq_in(dq_in),
    .dm_in(dm_in),
    .dq_out_q(dq_out_q),
    .dq_out_valid_q(dq_out_valid_q),
    .wr_beat(wr_beat),
    .zq_meas_ron(zq_meas_ron),
    .zq_meas_odt(zq_meas_odt),
    .ron_code_q(ron_code_q),
    .odt_code_q(odt_code_q),
    .zq_busy(zq_busy),
    .bank_open(bank_open),
    .bank_prech(bank_prech),
    .ref_row_q(ref_row_q),
    .ref_busy(ref_busy)
  );

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic results();
    $display("Compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Counts busy cycles; a flag that never drops ends the run
  task automatic wt(input logic z);
    #1;
    for (n = 0; n < 600 && (z ? zq_busy : ref_busy) === 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 600) begin
      fail_count++;
      results();
    end
  endtask

  task automatic wr8(input logic [15:0] s, input logic keep);
    logic [15:0] d;
    logic [1:0] m;
    ctl.issue(3'h4, 3'h1, 16'h1000);
    for (int k = 0; k < 8; k++) begin
      d = s ^ {2{8'(k)}};
      m = {keep & k[0], 1'h0};
      dq_in <= d;
      dm_in <= m;
      mem[k] = m[1] ? {mem[k][15:8], d[7:0]} : d;
      #1;
      chk("wr_beat", 16'h0001, {15'h0000, wr_beat});
      @(posedge clk);
    end
    dq_in <= ~d;
  endtask

  task automatic rd(input logic [2:0] s, input logic b8, input logic ap, input logic ilv);
    int j;
    logic [2:0] c;
    j = 0;
    burst_ilv <= ilv;
    ctl.issue(3'h5, 3'h1, {3'h0, b8, 1'h0, ap, 7'h00, s});
    repeat (12) begin
      @(posedge clk);
      #1;
      if (dq_out_valid_q === 1'h1) begin
        c = ilv ? s ^ 3'(j) : b8 ? s + 3'(j) : {s[2], s[1:0] + 2'(j)};
        chk("dq_out_q", mem[c], dq_out_q);
        j++;
      end
    end
    chk("beats", b8 ? 16'h0008 : 16'h0004, 16'(j));
  endtask

  task automatic t_data();
    ctl.issue(3'h3, 3'h1, 16'h0003);
    #1;
    chk("bank_open", 16'h0002, {8'h00, bank_open});
    wr8(16'hA5C3, 1'h0);
    wr8(16'h3C5A, 1'h1);
    rd(3'h2, 1'h1, 1'h0, 1'h0);
    rd(3'h5, 1'h0, 1'h0, 1'h1);
    rd(3'h3, 1'h1, 1'h1, 1'h1);
    chk("bank_state", 16'h0000, {bank_open, bank_prech});
    $display("t_data done");
  endtask

  task automatic t_pre();
    ctl.issue(3'h3, 3'h0, 16'h0001);
    ctl.issue(3'h3, 3'h2, 16'h0002);
    ctl.issue(3'h3, 3'h3, 16'h0001);
    ctl.issue(3'h2, 3'h2, 16'h0000);
    #1;
    chk("bank_open", 16'h0009, {8'h00, bank_open});
    ctl.issue(3'h2, 3'h2, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk("bank_prech", 16'h0004, {8'h00, bank_prech});
    @(posedge clk);
    #1;
    chk("bank_prech", 16'h0000, {8'h00, bank_prech});
    ctl.issue(3'h2, 3'h5, 16'h0000);
    #1;
    chk("bank_prech", 16'h0000, {8'h00, bank_prech});
    ctl.issue(3'h5, 3'h0, 16'h1400);
    repeat (7) @(posedge clk);
    otf_en <= 1'h0;
    ctl.issue(3'h5, 3'h3, 16'h0000);
    #1;
    chk("bank_prech", 16'h0001, {8'h00, bank_prech});
    n = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      n += int'(dq_out_valid_q);
    end
    otf_en <= 1'h1;
    chk("beats", 16'h0008, 16'(n));
    ctl.issue(3'h2, 3'h7, 16'h0400);
    #1;
    chk("bank_open", 16'h0000, {8'h00, bank_open});
    repeat (5) @(posedge clk);
    $display("t_pre done");
  endtask

  task automatic t_ref();
    logic [12:0] r;
    repeat (2) begin
      r = ref_row_q;
      ctl.issue(3'h1, 3'h5, 16'hFFFF);
      wt(1'h0);
      chk("ref_len", 16'(T_RFC_CYC), 16'(n));
      chk("ref_row", 16'(r + 13'h0001), {3'h0, ref_row_q});
    end
    $display("t_ref done");
  endtask

  task automatic t_zq();
    int w [3] = '{ZQCS_CYC, ZQOPER_CYC, ZQINIT_CYC};
    for (int i = 0; i < 3; i++) begin
      zq_meas_ron <= 6'(i * 9 + 5);
      zq_meas_odt <= 6'(i * 7 + 3);
      init_done <= (i != 2);
      ctl.issue(3'h6, 3'h0, i == 0 ? 16'h0000 : 16'h0400);
      wt(1'h1);
      chk("zq_len", 16'(w[i]), 16'(n));
      chk("codes", 16'((i * 9 + 5) * 64 + i * 7 + 3), {4'h0, ron_code_q, odt_code_q});
    end
    $display("t_zq done");
  endtask

  // Mid-run reset must clear codes and the refresh row too
  task automatic t_rst();
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("rst_codes", 16'h0000, {4'h0, ron_code_q, odt_code_q});
    chk("rst_row", 16'h0000, {3'h0, ref_row_q});
    chk("rst_busy", 16'h0000, {14'h0000, zq_busy, ref_busy});
    chk("rst_bank", 16'h0000, {bank_open, bank_prech});
    $display("t_rst done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset_state", 16'h0000, {bank_open, bank_prech});
    t_data();
    t_pre();
    t_ref();
    t_zq();
    t_rst();
    results();
  end
endmodule
